// [common/dpll_pkg.sv]
// Functional notes
// (R1) exactly five states: free-run, acquire, normal, holdover, hitless switch; one-hot
// (R2) free-run issues no frequency control words on the steering bus; the code still sends the DCO word in free-run when DCO is set
// (R3) acquire tracks with acquisition gain, moves to normal on lock
// (R4) normal tracks with normal gain so frequency follows the reference
// (R5) holdover emits words from history averaged during normal
// (R6) hitless switch acts as holdover while measuring and storing phase offset
// (R7) hitless enabled: reference change in acquire/normal goes via offset capture to acquire
// (R8) leaving holdover for acquire may use offset capture when hitless enabled
// (R9) hitless disabled: no stored offset, phase error driven to zero
// (R10) lock only to references from 1 kHz to 33 MHz
// (R11) up to five candidate reference inputs
// (R12) loop bandwidth programmable, 1 mHz to 1 kHz, as gain shift codes
// (R13) DCO mode ignores references; words follow software steering value
// (R14) external feedback must match the selected reference frequency
// (R15) forced or automatic priority selection with revertive policy and GPIO LOS
// (R16) phase steps smoothed by loop filter and phase slope limiter
// (R17) monitors check loss of signal and frequency offset per thresholds
// (R18) words go to the synthesizer over the steering bus
// (R19) lock when error within threshold for qualification interval, dropped on exit
package dpll_pkg;
   localparam int NREF = 5;
   localparam int CLK_HZ = 20_000_000;
   localparam int REF_MIN_HZ = 1_000;
   localparam int REF_MAX_HZ = 33_000_000;
   localparam int MON_WIN_US = 1_000;
   localparam logic [31:0] MON_WIN_CYC = 32'(MON_WIN_US * (CLK_HZ / 1_000_000));
   // edges counted in a 1 ms window: 1 kHz gives 1, 33 MHz gives 33000
   localparam logic [15:0] MON_MIN_EDGES = 16'(REF_MIN_HZ / 1_000);
   localparam logic [15:0] MON_MAX_EDGES = 16'(REF_MAX_HZ / 1_000);

   localparam logic [11:0] A_CTRL = 12'h000;
   localparam logic [11:0] A_PRIO = 12'h004;
   localparam logic [11:0] A_LOCK = 12'h008;
   localparam logic [11:0] A_BW = 12'h00C;
   localparam logic [11:0] A_DCO = 12'h010;
   localparam logic [11:0] A_STAT = 12'h014;
   localparam logic [11:0] A_IRQ = 12'h018;
   localparam logic [11:0] A_MASK = 12'h01C;
   localparam logic [11:0] A_FOFF = 12'h020;
   localparam logic [11:0] A_PHOFF = 12'h024;
   localparam logic [11:0] A_FCW = 12'h028;
   localparam logic [11:0] A_SLOPE = 12'h02C;

   localparam int C_EN = 0;
   localparam int C_AUTO = 1;
   localparam int C_REV = 2;
   localparam int C_HITLESS = 3;
   localparam int C_DCO = 4;
   localparam int C_EXTFB = 5;
   localparam int C_FSEL = 8;
   localparam int C_FBSEL = 12;

   localparam int IRQ_LOCK = 0;
   localparam int IRQ_UNLOCK = 1;
   localparam int IRQ_SWITCH = 2;
   localparam int IRQ_HOLD = 3;
   localparam int IRQ_REFBAD = 4;
   localparam int NIRQ = 5;

   localparam logic [31:0] CTRL_RST = 32'h0000_0007;
   localparam logic [31:0] PRIO_RST = 32'h0004_3210;
   localparam logic [31:0] LOCK_RST = 32'h0010_0040;
   localparam logic [31:0] BW_RST = 32'h0000_0A64;
   localparam logic [31:0] FOFF_RST = 32'h0000_0010;
   localparam logic [31:0] SLOPE_RST = 32'h0000_0100;
   localparam logic [1:0] RESP_OK = 2'h0;
   localparam logic [1:0] RESP_SLV = 2'h2;

   typedef enum logic [4:0] {
      ST_FREE = 5'h01,
      ST_ACQ = 5'h02,
      ST_NORM = 5'h04,
      ST_HOLD = 5'h08,
      ST_HITLESS = 5'h10
   } dpll_state_t;

   typedef struct packed {
      logic [31:0] ctrl;
      logic [31:0] prio;
      logic [31:0] lock;
      logic [31:0] bw;
      logic [31:0] dco;
      logic [31:0] foff;
      logic [31:0] slope;
      logic [NIRQ-1:0] irq;
      logic [NIRQ-1:0] mask;
   } regs_t;

   typedef struct packed {
      logic valid;
      logic [31:0] fcw;
   } steer_t;
endpackage : dpll_pkg

// [verilog/dpll_ctrl.sv]
`timescale 1ns/100ps
`default_nettype none
module dpll_ctrl
   import dpll_pkg::*;
(
   // clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // axi4-lite write
   input wire logic [11:0] s_awaddr,
   input wire logic s_awvalid,
   output logic s_awready,
   input wire logic [31:0] s_wdata,
   input wire logic [3:0] s_wstrb,
   input wire logic s_wvalid,
   output logic s_wready,
   output logic [1:0] s_bresp,
   output logic s_bvalid,
   input wire logic s_bready,
   // axi4-lite read
   input wire logic [11:0] s_araddr,
   input wire logic s_arvalid,
   output logic s_arready,
   output logic [31:0] s_rdata,
   output logic [1:0] s_rresp,
   output logic s_rvalid,
   input wire logic s_rready,
   // references and feedback, asynchronous pins
   input wire logic [NREF-1:0] ref_clk,
   input wire logic [NREF-1:0] gpio_los,
   input wire logic fb_int,
   // steering bus and status
   output steer_t steer,
   output dpll_state_t dpll_state,
   output logic locked,
   output logic irq
);
   typedef struct packed {
      logic [NREF-1:0] s1r, s2r, s3r, s1l, s2l;
      logic s1f, s2f, s3f;
      logic [NREF-1:0][15:0] edges;
      logic [NREF-1:0] qual;
      logic [NREF-1:0] use_d;
      logic [31:0] win;
      dpll_state_t st;
      logic [2:0] sel;
      logic [15:0] cap_cnt;
      logic signed [31:0] ph;
      logic signed [31:0] phoff;
      logic signed [31:0] perr;
      logic signed [31:0] integ;
      logic signed [31:0] hist;
      logic [31:0] fcw;
      logic fvalid;
      logic [15:0] lock_cnt;
      logic lk;
      regs_t r;
      logic aw_got, w_got;
      logic [11:0] awa;
      logic [31:0] wd;
      logic bv;
      logic rv;
      logic [31:0] rd;
      logic [1:0] rr;
      logic [1:0] br;
   } state_t;

   state_t q_ff, nxt_q;

   logic [NREF-1:0] rise;
   logic [NREF-1:0] usable;
   logic fb_rise;
   logic [2:0] best;
   logic [2:0] want;
   logic signed [31:0] raw, slew, prop, corr;
   logic [3:0] shp, shi;
   logic wr_go;
   // events of this cycle; merged before the bus so a clear never hides one
   logic [NIRQ-1:0] ev;

   // monitor per input: edge counts in a window against range and offset thresholds
   genvar g;
   generate
      for (g = 0; g < NREF; g++) begin : g_mon
         assign rise[g] = q_ff.s2r[g] & ~q_ff.s3r[g];
         // both loss and frequency offset disqualify a reference; see (R17) (R10)
         assign usable[g] = q_ff.qual[g] & ~q_ff.s2l[g];  // see (R15)
      end
   endgenerate
   assign fb_rise = q_ff.s2f & ~q_ff.s3f;

   // automatic pick: lowest priority code among usable inputs
   // equal codes resolve to the higher input index
   always_comb begin
      best = q_ff.sel;
      for (int i = NREF - 1; i >= 0; i--) begin
         for (int j = 0; j < NREF; j++) begin
            if (usable[j] && q_ff.r.prio[j*4 +: 3] == 3'(i)) begin
               best = 3'(j);
            end
         end
      end
   end

   always_comb begin
      if (!q_ff.r.ctrl[C_AUTO]) begin
         want = q_ff.r.ctrl[C_FSEL +: 3];  // see (R15)
      end else if (q_ff.r.ctrl[C_REV] || !usable[q_ff.sel]) begin
         want = best;  // see (R15)
      end else begin
         want = q_ff.sel;  // non-revertive keeps a good reference
      end
   end

   always_comb begin
      // gains per state; shift codes span the bandwidth range; see (R12)
      shp = (q_ff.st == ST_ACQ) ? q_ff.r.bw[3:0] : q_ff.r.bw[11:8];  // see (R3) (R4)
      shi = (q_ff.st == ST_ACQ) ? q_ff.r.bw[7:4] : q_ff.r.bw[15:12];
      raw = q_ff.ph - q_ff.phoff;  // see (R7) (R9)
      // slope limiter caps each step of the phase error at the slope value per cycle; see (R16)
      if (raw - q_ff.perr > $signed(q_ff.r.slope)) begin
         slew = q_ff.perr + $signed(q_ff.r.slope);
      end else if (q_ff.perr - raw > $signed(q_ff.r.slope)) begin
         slew = q_ff.perr - $signed(q_ff.r.slope);
      end else begin
         slew = raw;
      end
      prop = slew >>> shp;
      corr = prop + (q_ff.integ >>> shi);
   end

   // response held until taken, so no second write lands meanwhile
   assign wr_go = q_ff.aw_got & q_ff.w_got & ~q_ff.bv;

   always_comb begin
      nxt_q = q_ff;
      ev = '0;
      // pins pass two flops before any logic reads them, except the feedback pin select ahead of the first flop
      nxt_q.s1r = ref_clk;
      nxt_q.s2r = q_ff.s1r;
      nxt_q.s3r = q_ff.s2r;
      nxt_q.s1l = gpio_los;
      nxt_q.s2l = q_ff.s1l;
      // external feedback uses a reference pin; it must match the reference; see (R14)
      nxt_q.s1f = q_ff.r.ctrl[C_EXTFB] ? ref_clk[q_ff.r.ctrl[C_FBSEL +: 3]] : fb_int;
      nxt_q.s2f = q_ff.s1f;
      nxt_q.s3f = q_ff.s2f;
      nxt_q.fvalid = 1'b0;
      nxt_q.use_d = usable;

      // window monitor; a new input qualifies only after up to two windows
      nxt_q.win = q_ff.win + 32'h1;
      for (int k = 0; k < NREF; k++) begin
         nxt_q.edges[k] = q_ff.edges[k] + {15'h0, rise[k]};
      end
      if (q_ff.win >= MON_WIN_CYC - 32'h1) begin
         nxt_q.win = 32'h0;
         for (int k = 0; k < NREF; k++) begin
            nxt_q.edges[k] = 16'h0;
            nxt_q.qual[k] = q_ff.edges[k] >= MON_MIN_EDGES
               && q_ff.edges[k] <= MON_MAX_EDGES
               && q_ff.edges[k] >= q_ff.r.foff[15:0]
               && q_ff.edges[k] <= q_ff.r.foff[31:16] + MON_MAX_EDGES;  // see (R17) (R10)
            if (q_ff.qual[k] && !nxt_q.qual[k] && 3'(k) == q_ff.sel) begin
               ev[IRQ_REFBAD] = 1'b1;
            end
         end
      end

      // phase detector: reference edge adds, feedback edge subtracts
      nxt_q.ph = q_ff.ph + {31'h0, rise[q_ff.sel]} - {31'h0, fb_rise};

      // lock qualifier; see (R19)
      if ((q_ff.st == ST_ACQ || q_ff.st == ST_NORM)
          && (q_ff.perr <= $signed({16'h0, q_ff.r.lock[15:0]})
          && q_ff.perr >= -$signed({16'h0, q_ff.r.lock[15:0]}))) begin
         if (q_ff.lock_cnt >= q_ff.r.lock[31:16]) begin
            nxt_q.lk = 1'b1;
         end else begin
            nxt_q.lock_cnt = q_ff.lock_cnt + 16'h1;
         end
      end else begin
         nxt_q.lock_cnt = 16'h0;
         nxt_q.lk = 1'b0;
      end
      if (nxt_q.lk && !q_ff.lk) ev[IRQ_LOCK] = 1'b1;
      if (!nxt_q.lk && q_ff.lk) ev[IRQ_UNLOCK] = 1'b1;
      // gpio loss or a failed window on the tracked input disqualifies it; see (R15)
      if (q_ff.st != ST_FREE && q_ff.use_d[q_ff.sel] && !usable[q_ff.sel]) begin
         ev[IRQ_REFBAD] = 1'b1;
      end

      // state machine; see (R1)
      case (q_ff.st)
         ST_FREE: begin
            // silent on the steering bus except in DCO mode, which sends the software word; see (R2)
            if (q_ff.r.ctrl[C_EN] && !q_ff.r.ctrl[C_DCO] && usable[want]) begin
               nxt_q.sel = want;
               nxt_q.perr = 32'sh0;
               nxt_q.ph = 32'sh0;
               nxt_q.phoff = 32'sh0;
               nxt_q.st = ST_ACQ;
            end
         end
         ST_ACQ, ST_NORM: begin
            nxt_q.perr = slew;
            nxt_q.integ = q_ff.integ + slew;
            nxt_q.fcw = 32'(q_ff.hist) + 32'(corr);  // see (R3) (R4) (R18)
            nxt_q.fvalid = 1'b1;
            if (q_ff.st == ST_NORM) begin
               // slow average of the loop correction as holdover history; see (R5)
               nxt_q.hist = q_ff.hist + ((32'(corr) - q_ff.hist) >>> 4);
            end
            if (q_ff.st == ST_ACQ && q_ff.lk) nxt_q.st = ST_NORM;  // see (R3)
            if (!q_ff.r.ctrl[C_EN] || q_ff.r.ctrl[C_DCO]) begin
               nxt_q.st = ST_FREE;
            end else if (!usable[q_ff.sel] && want == q_ff.sel) begin
               nxt_q.st = ST_HOLD;
               ev[IRQ_HOLD] = 1'b1;
            end else if (want != q_ff.sel) begin
               // switch drops lock so the new input is qualified afresh
               nxt_q.sel = want;
               ev[IRQ_SWITCH] = 1'b1;
               nxt_q.lk = 1'b0;
               nxt_q.lock_cnt = 16'h0;
               if (q_ff.r.ctrl[C_HITLESS]) begin
                  nxt_q.st = ST_HITLESS;  // see (R7)
                  nxt_q.cap_cnt = 16'h0;
                  nxt_q.ph = 32'sh0;
               end else begin
                  nxt_q.phoff = 32'sh0;  // see (R9)
                  nxt_q.st = ST_ACQ;
               end
            end
         end
         ST_HOLD: begin
            // frozen history word, no loop update
            nxt_q.fcw = 32'(q_ff.hist);  // see (R5)
            nxt_q.fvalid = 1'b1;
            if (!q_ff.r.ctrl[C_EN] || q_ff.r.ctrl[C_DCO]) begin
               nxt_q.st = ST_FREE;
            end else if (usable[want]) begin
               nxt_q.sel = want;
               nxt_q.ph = 32'sh0;
               if (q_ff.r.ctrl[C_HITLESS]) begin
                  nxt_q.st = ST_HITLESS;  // see (R8)
                  nxt_q.cap_cnt = 16'h0;
               end else begin
                  nxt_q.phoff = 32'sh0;  // see (R9)
                  nxt_q.st = ST_ACQ;
               end
            end
         end
         ST_HITLESS: begin
            // holdover words while the offset is measured; see (R6)
            nxt_q.fcw = 32'(q_ff.hist);
            nxt_q.fvalid = 1'b1;
            nxt_q.cap_cnt = q_ff.cap_cnt + 16'h1;
            if (q_ff.cap_cnt >= q_ff.r.lock[31:16]) begin
               nxt_q.phoff = q_ff.ph;  // see (R6) (R7)
               nxt_q.perr = 32'sh0;
               nxt_q.st = ST_ACQ;
            end
            if (!usable[q_ff.sel]) nxt_q.st = ST_HOLD;
            if (!q_ff.r.ctrl[C_EN] || q_ff.r.ctrl[C_DCO]) nxt_q.st = ST_FREE;
         end
         default: nxt_q.st = ST_FREE;
      endcase

      // dco: software word replaces the loop output; see (R13)
      if (q_ff.r.ctrl[C_DCO]) begin
         nxt_q.fcw = q_ff.r.dco;
         nxt_q.fvalid = 1'b1;
      end

      // events first; a write-one-clear below drops only older bits
      nxt_q.r.irq = q_ff.r.irq | ev;

      // axi4-lite write
      if (s_awvalid && !q_ff.aw_got) begin
         nxt_q.aw_got = 1'b1;
         nxt_q.awa = s_awaddr;
      end
      if (s_wvalid && !q_ff.w_got) begin
         nxt_q.w_got = 1'b1;
         nxt_q.wd = s_wdata;
      end
      if (wr_go) begin
         nxt_q.aw_got = 1'b0;
         nxt_q.w_got = 1'b0;
         nxt_q.bv = 1'b1;
         nxt_q.br = RESP_OK;
         case (q_ff.awa & 12'hFFC)
            A_CTRL: nxt_q.r.ctrl = q_ff.wd;
            A_PRIO: nxt_q.r.prio = q_ff.wd;
            A_LOCK: nxt_q.r.lock = q_ff.wd;
            A_BW: nxt_q.r.bw = q_ff.wd;
            A_DCO: nxt_q.r.dco = q_ff.wd;
            A_FOFF: nxt_q.r.foff = q_ff.wd;
            A_SLOPE: nxt_q.r.slope = q_ff.wd;
            A_MASK: nxt_q.r.mask = q_ff.wd[NIRQ-1:0];
            // write one clears, but a new event in the same cycle wins
            A_IRQ: nxt_q.r.irq = (q_ff.r.irq & ~q_ff.wd[NIRQ-1:0])
               | ev;
            A_STAT, A_PHOFF, A_FCW: ;
            default: nxt_q.br = RESP_SLV;
         endcase
      end
      if (q_ff.bv && s_bready) nxt_q.bv = 1'b0;

      // axi4-lite read; data frozen while rvalid waits
      if (s_arvalid && !q_ff.rv) begin
         nxt_q.rv = 1'b1;
         nxt_q.rr = RESP_OK;
         case (s_araddr & 12'hFFC)
            A_CTRL: nxt_q.rd = q_ff.r.ctrl;
            A_PRIO: nxt_q.rd = q_ff.r.prio;
            A_LOCK: nxt_q.rd = q_ff.r.lock;
            A_BW: nxt_q.rd = q_ff.r.bw;
            A_DCO: nxt_q.rd = q_ff.r.dco;
            A_STAT: begin
               // usable at 20:16, window results at 13:9, then lock, select, state
               nxt_q.rd = {11'h0, usable, 2'h0, q_ff.qual, q_ff.lk, q_ff.sel, q_ff.st};
            end
            A_IRQ: nxt_q.rd = {27'h0, q_ff.r.irq};
            A_MASK: nxt_q.rd = {27'h0, q_ff.r.mask};
            A_FOFF: nxt_q.rd = q_ff.r.foff;
            A_PHOFF: nxt_q.rd = q_ff.phoff;
            A_FCW: nxt_q.rd = q_ff.fcw;
            A_SLOPE: nxt_q.rd = q_ff.r.slope;
            default: begin
               nxt_q.rd = 32'h0;
               nxt_q.rr = RESP_SLV;
            end
         endcase
      end
      if (q_ff.rv && s_rready) nxt_q.rv = 1'b0;
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         // configuration starts enabled, automatic and revertive
         q_ff <= '0;
         q_ff.st <= ST_FREE;
         q_ff.r.ctrl <= CTRL_RST;
         q_ff.r.prio <= PRIO_RST;
         q_ff.r.lock <= LOCK_RST;
         q_ff.r.bw <= BW_RST;
         q_ff.r.foff <= FOFF_RST;
         q_ff.r.slope <= SLOPE_RST;
      end else begin
         q_ff <= nxt_q;
      end
   end

   assign s_awready = ~q_ff.aw_got;
   assign s_wready = ~q_ff.w_got;
   assign s_bvalid = q_ff.bv;
   assign s_bresp = q_ff.br;
   assign s_arready = ~q_ff.rv;
   assign s_rvalid = q_ff.rv;
   assign s_rdata = q_ff.rd;
   assign s_rresp = q_ff.rr;
   assign steer.valid = q_ff.fvalid;  // see (R18)
   assign steer.fcw = q_ff.fcw;
   assign dpll_state = q_ff.st;
   assign locked = q_ff.lk;
   // level output, follows status and mask with no extra delay
   assign irq = |(q_ff.r.irq & q_ff.r.mask);
endmodule : dpll_ctrl
`default_nettype wire

// [verif/synth_model.sv]
`timescale 1ns/100ps
`default_nettype none
module synth_model
   import dpll_pkg::*;
(
   // clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // steering bus in, divided output back
   input wire steer_t steer,
   output logic fb_clk,
   output logic [31:0] words
);
   logic [8:0] div_ff;
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         div_ff <= '0;
         words <= '0;
      end else begin
         div_ff <= div_ff + 9'h001;
         // no handshake on this bus, so every word is taken
         if (steer.valid) words <= words + 32'h1;
      end
   end
   // nominal output divided to the rate of bench reference ref0
   assign fb_clk = div_ff[8];
endmodule : synth_model
`default_nettype wire

// [verif/dpll_ctrl_properties.sv]
`timescale 1ns/100ps
`default_nettype none
module dpll_ctrl_properties
   import dpll_pkg::*;
(
   // clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // read channel
   input wire logic s_arvalid,
   input wire logic s_arready,
   input wire logic s_rvalid,
   input wire logic s_rready,
   input wire logic [31:0] s_rdata,
   // loop outputs
   input wire steer_t steer,
   input wire dpll_state_t dpll_state,
   input wire logic locked
);
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   AST_ONE_STATE: assert property ($onehot(dpll_state))
      else $error("state not one-hot");
   AST_STEER_ON: assert property ((dpll_state != ST_FREE) [*2] |-> steer.valid)
      else $error("no word while tracking or holding");
   AST_LOCK_NORM: assert property ($rose(locked) |-> ##[0:2] dpll_state == ST_NORM)
      else $error("lock without normal");
   AST_NORM_ENTRY: assert property ($rose(dpll_state == ST_NORM) |->
      $past(dpll_state) == ST_ACQ)
      else $error("normal not entered from acquire");
   AST_HIT_ENTRY: assert property ($rose(dpll_state == ST_HITLESS) |->
      $past(dpll_state) inside {ST_ACQ, ST_NORM, ST_HOLD})
      else $error("hitless entered from free-run");
   AST_HIT_EXIT: assert property ($fell(dpll_state == ST_HITLESS) |->
      dpll_state != ST_NORM)
      else $error("hitless left straight to normal");
   AST_HOLD_ENTRY: assert property ($rose(dpll_state == ST_HOLD) |->
      $past(dpll_state) != ST_FREE)
      else $error("holdover without history");
   AST_FREE_UNLOCK: assert property ((dpll_state == ST_FREE) [*2] |-> !locked)
      else $error("locked in free-run");
   AST_RD_ANSWER: assert property (s_arvalid && s_arready |=> s_rvalid)
      else $error("read not answered next cycle");
   AST_RD_HOLD: assert property (s_rvalid && !s_rready |=> s_rvalid && $stable(s_rdata))
      else $error("read data dropped");
endmodule : dpll_ctrl_properties
`default_nettype wire

// [verif/tb.sv]
`timescale 1ns/100ps
`default_nettype none
module tb;
   import dpll_pkg::*;
   logic aclk = 1'h0, aresetn = 1'h0;
   logic [11:0] s_awaddr = '0, s_araddr = '0;
   logic [31:0] s_wdata = '0;
   logic s_awvalid = 1'h0, s_wvalid = 1'h0, s_bready = 1'h0, s_arvalid = 1'h0, s_rready = 1'h0;
   logic [NREF-1:0] ref_clk = '0, gpio_los = '0;
   logic s_awready, s_wready, s_bvalid, s_arready, s_rvalid, locked, irq, fb_int;
   logic [1:0] s_bresp, s_rresp;
   logic [31:0] s_rdata, words, dco_w;
   logic [15:0] cnt = '0;
   logic [65:0] re;
   logic [65:0] rq[$];
   logic [1:0] bq[$];
   steer_t steer;
   dpll_state_t dpll_state;
   int errors = 0, checks_done = 0;
   logic [11:0] ra[7] = '{A_CTRL, A_PRIO, A_LOCK, A_BW, A_FOFF, A_SLOPE, 12'h0FC};
   logic [31:0] rv[7] = '{CTRL_RST, PRIO_RST, LOCK_RST, BW_RST, FOFF_RST, SLOPE_RST, 32'h0};

   dpll_ctrl u_dpll_ctrl (.aclk(aclk), .aresetn(aresetn), .s_awaddr(s_awaddr),
      .s_awvalid(s_awvalid), .s_awready(s_awready), .s_wdata(s_wdata), .s_wstrb(4'hF),
      .s_wvalid(s_wvalid), .s_wready(s_wready), .s_bresp(s_bresp), .s_bvalid(s_bvalid),
      .s_bready(s_bready), .s_araddr(s_araddr), .s_arvalid(s_arvalid), .s_arready(s_arready),
      .s_rdata(s_rdata), .s_rresp(s_rresp), .s_rvalid(s_rvalid), .s_rready(s_rready),
      .ref_clk(ref_clk), .gpio_los(gpio_los), .fb_int(fb_int), .steer(steer),
      .dpll_state(dpll_state), .locked(locked), .irq(irq));
   synth_model u_synth_model (.aclk(aclk), .aresetn(aresetn), .steer(steer), .fb_clk(fb_int),
      .words(words));

   always #25 aclk = ~aclk;
   always @(posedge aclk) begin
      cnt <= cnt + 16'h1;
      // ref1 and ref4 stay idle, below the lock range
      ref_clk <= {1'h0, ~ref_clk[3], cnt[7] ^ cnt[8], 1'h0, cnt[8]};
   end

   task automatic cmp_v(input logic [31:0] got, input logic [31:0] exp, input string what);
      checks_done++;
      if (got !== exp) begin
         errors++;
         $display("BAD %0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask : cmp_v
   task automatic cmp_rd(input logic [31:0] gd, ed, input logic [1:0] gr, er);
      cmp_v(gd, ed, "rdata");
      cmp_v({30'h0, gr}, {30'h0, er}, "rresp");
   endtask : cmp_rd
   task automatic cmp_b(input logic [1:0] gr, er);
      cmp_v({30'h0, gr}, {30'h0, er}, "bresp");
   endtask : cmp_b

   always @(posedge aclk) begin
      if (s_rvalid && s_rready) begin
         re = rq.pop_front();
         cmp_rd(s_rdata & re[63:32], re[31:0], s_rresp, re[65:64]);
      end
      if (s_bvalid && s_bready) cmp_b(s_bresp, bq.pop_front());
   end

   task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] r);
      int n;
      @(posedge aclk);
      bq.push_back(r);
      s_awaddr <= a;
      s_wdata <= d;
      s_awvalid <= 1'h1;
      s_wvalid <= 1'h1;
      s_bready <= 1'h1;
      n = 0;
      do begin
         @(posedge aclk);
         if (s_awready) s_awvalid <= 1'h0;
         if (s_wready) s_wvalid <= 1'h0;
         n++;
      end while (!(s_bvalid && s_bready) && n < 1000);
      s_bready <= 1'h0;
      if (n >= 1000) cmp_v(32'h0, 32'h1, "write hang");
   endtask : wr
   task automatic rd(input logic [11:0] a, input logic [31:0] e, m, input logic [1:0] r);
      int n;
      @(posedge aclk);
      rq.push_back({r, m, e & m});
      s_araddr <= a;
      s_arvalid <= 1'h1;
      s_rready <= 1'h1;
      n = 0;
      do begin
         @(posedge aclk);
         if (s_arready) s_arvalid <= 1'h0;
         n++;
      end while (!(s_rvalid && s_rready) && n < 1000);
      s_rready <= 1'h0;
      if (n >= 1000) cmp_v(32'h0, 32'h1, "read hang");
   endtask : rd
   task automatic wait_st(input dpll_state_t s, input int lim, input string what);
      int n;
      n = 0;
      while (dpll_state !== s && n < lim) begin
         @(posedge aclk);
         n++;
      end
      cmp_v({27'h0, dpll_state}, {27'h0, s}, what);
   endtask : wait_st
   task automatic cnt_words(input logic [31:0] exp, input string what);
      logic [31:0] w0;
      w0 = words;
      repeat (10) @(posedge aclk);
      cmp_v(words - w0, exp, what);
   endtask : cnt_words
   task automatic results;
      $display("checks %0d errors %0d", checks_done, errors);
      if (errors == 0 && checks_done > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask : results

   initial begin
      #5_000_000;
      errors++;
      $display("BAD %0t watchdog expired", $time);
      results();
   end

   initial begin
      void'($urandom(32'hF97D7BEB));
      dco_w = $urandom();
      repeat (3) @(posedge aclk);
      aresetn <= 1'h1;
      for (int i = 0; i < 7; i++) rd(ra[i], rv[i], 32'hFFFFFFFF, i == 6 ? RESP_SLV : RESP_OK);
      $display("test registers done");
      wr(A_MASK, 32'h1F, RESP_OK);
      // auto pick of ref0, feedback taken from the same pin
      wr(A_CTRL, 32'h27, RESP_OK);
      wait_st(ST_NORM, 60000, "lock");
      cmp_v({31'h0, locked}, 32'h1, "locked");
      cnt_words(32'hA, "words in normal");
      rd(A_IRQ, 32'h1, 32'h1, RESP_OK);
      wr(A_MASK, 32'h0, RESP_OK);
      cmp_v({31'h0, irq}, 32'h0, "irq masked");
      wr(A_IRQ, 32'h1F, RESP_OK);
      wr(A_MASK, 32'h1F, RESP_OK);
      cmp_v({31'h0, irq}, 32'h0, "irq cleared");
      $display("test lock done");
      wr(A_CTRL, 32'h2229, RESP_OK);
      wait_st(ST_HITLESS, 200, "switch capture");
      wait_st(ST_ACQ, 200, "switch acquire");
      wait_st(ST_NORM, 20000, "switch relock");
      rd(A_IRQ, 32'h4, 32'h4, RESP_OK);
      $display("test hitless done");
      gpio_los <= 5'h04;
      wait_st(ST_HOLD, 45000, "loss to holdover");
      cnt_words(32'hA, "words in holdover");
      rd(A_IRQ, 32'h18, 32'h18, RESP_OK);
      wr(A_CTRL, 32'h3329, RESP_OK);
      wait_st(ST_HITLESS, 200, "leave holdover");
      wait_st(ST_NORM, 20000, "relock ref3");
      $display("test holdover done");
      wr(A_DCO, dco_w, RESP_OK);
      wr(A_CTRL, 32'h11, RESP_OK);
      repeat (20) @(posedge aclk);
      cmp_v(steer.fcw, dco_w, "dco word");
      cmp_v({31'h0, steer.valid}, 32'h1, "dco valid");
      wr(A_CTRL, 32'h0, RESP_OK);
      wait_st(ST_FREE, 100, "disable");
      repeat (2) @(posedge aclk);
      cnt_words(32'h0, "words in free-run");
      $display("test dco and free-run done");
      results();
   end
endmodule : tb
bind dpll_ctrl dpll_ctrl_properties u_dpll_ctrl_properties (.aclk(aclk), .aresetn(aresetn),
   .s_arvalid(s_arvalid), .s_arready(s_arready), .s_rvalid(s_rvalid), .s_rready(s_rready),
   .s_rdata(s_rdata), .steer(steer), .dpll_state(dpll_state), .locked(locked));
`default_nettype wire
